// ### hw/press_readout.sv
/*
 Pressure readout top: holding register, bus condition detection on
 mclk and the serial slave engine clocked by the bus clock scl.
 Assumes an external master drives scl; sda is open drain.
*/
`timescale 1ns/1ps
module press_readout
	import press_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DEF,
	parameter logic SEC_ADDR_EN = 1'b0,
	parameter logic [6:0] SEC_ADDR = 7'h00
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda_i,
	input wire logic [ADC_BITS-1:0] adc_raw,
	output logic sda_o,
	output logic sda_oe,
	output logic [PRESS_BITS-1:0] pressure,
	output logic bus_busy
);
	conv_if cv ();

	conv_unit #(
		.CONV_CYCLES(CONV_CYCLES)
	) u_conv (
		.mclk(mclk),
		.srst(srst),
		.adc_raw(adc_raw),
		.cv(cv)
	);

	// core side: line sampling
	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic scl_f;
	logic sda_f;
	logic next_scl_f;
	logic next_sda_f;
	logic start_ev;
	logic stop_ev;

	always_comb
	begin
		next_scl_f = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
		next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
		start_ev = scl_f & next_scl_f & sda_f & ~next_sda_f;
		stop_ev = scl_f & next_scl_f & ~sda_f & next_sda_f;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
		end
		else
		begin
			scl_s <= {scl_s[1:0], scl};
			sda_s <= {sda_s[1:0], sda_i};
			scl_f <= next_scl_f;
			sda_f <= next_sda_f;
		end
	end

	// core side: holding register, frame tracking, pin drive
	logic [PRESS_BITS-1:0] snapshot;
	logic start_tog;
	logic bus_active;
	logic back_s1;
	logic back_s2;
	logic drv_s1;
	logic drv_s2;
	logic seen;
	logic drive;
	logic [PRESS_BITS-1:0] next_pressure;
	logic [PRESS_BITS-1:0] next_snapshot;
	logic next_start_tog;
	logic next_bus_active;
	logic next_sda_oe;

	always_comb
	begin
		next_pressure = pressure;
		next_snapshot = snapshot;
		next_start_tog = start_tog;
		next_bus_active = bus_active;
		if (cv.tick)
			next_pressure = cv.result;
		if (start_ev)
		begin
			next_snapshot = pressure;
			next_start_tog = ~start_tog;
			next_bus_active = 1'b1;
		end
		else if (stop_ev)
			next_bus_active = 1'b0;
		// release unless the engine owns this frame
		next_sda_oe = drv_s2 & next_bus_active & ~start_ev & (back_s2 == start_tog);
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pressure <= PRESS_RESET;
			snapshot <= PRESS_RESET;
			start_tog <= 1'b0;
			bus_active <= 1'b0;
			back_s1 <= 1'b0;
			back_s2 <= 1'b0;
			drv_s1 <= 1'b0;
			drv_s2 <= 1'b0;
			sda_oe <= 1'b0;
			sda_o <= 1'b0;
			bus_busy <= 1'b0;
		end
		else
		begin
			pressure <= next_pressure;
			snapshot <= next_snapshot;
			start_tog <= next_start_tog;
			bus_active <= next_bus_active;
			back_s1 <= seen;
			back_s2 <= back_s1;
			drv_s1 <= drive;
			drv_s2 <= drv_s1;
			sda_oe <= next_sda_oe;
			sda_o <= 1'b0;
			bus_busy <= next_bus_active;
		end
	end

	// link side: bit capture during the clock high phase
	logic [7:0] rx_sh;

	always_ff @(posedge scl or posedge srst)
	begin
		if (srst)
			rx_sh <= 8'h00;
		else
			rx_sh <= {rx_sh[6:0], sda_i};
	end

	// link side: control advances on the falling clock edge
	link_state_t state;
	link_state_t next_state;
	logic tog_s1;
	logic tog_s2;
	logic [3:0] cnt;
	logic [15:0] tx_sh;
	logic is_read;
	logic second;
	logic next_seen;
	logic next_drive;
	logic [3:0] next_cnt;
	logic [15:0] next_tx_sh;
	logic next_is_read;
	logic next_second;
	logic addr_hit;

	always_comb
	begin
		next_state = state;
		next_seen = seen;
		next_drive = drive;
		next_cnt = cnt + 1'b1;
		next_tx_sh = tx_sh;
		next_is_read = is_read;
		next_second = second;
		addr_hit = (rx_sh[7:1] == PRIMARY_ADDR) || (SEC_ADDR_EN && rx_sh[7:1] == SEC_ADDR);
		if (tog_s2 != seen)
		begin
			next_seen = tog_s2;
			next_state = LK_ADDR;
			next_cnt = BITS_AT_SYNC;
			next_drive = 1'b0;
		end
		else
		begin
			case (state)
				LK_ADDR:
				begin
					if (cnt == BIT_LAST)
					begin
						next_cnt = '0;
						next_is_read = rx_sh[0];
						if (addr_hit)
						begin
							next_state = LK_ADDR_ACK;
							next_drive = 1'b1;
						end
						else
							next_state = LK_IDLE;
					end
				end
				LK_ADDR_ACK:
				begin
					next_cnt = '0;
					next_second = 1'b0;
					if (is_read)
					begin
						// two bytes of the latched value
						next_tx_sh = {1'b0, snapshot};
						next_drive = ~next_tx_sh[15];
						next_state = LK_TX;
					end
					else
					begin
						next_drive = 1'b0;
						next_state = LK_RX;
					end
				end
				LK_TX:
				begin
					// next bit set up while clock low
					next_tx_sh = {tx_sh[14:0], 1'b0};
					if (cnt == BIT_LAST)
					begin
						next_cnt = '0;
						next_drive = 1'b0;
						next_state = LK_TX_ACK;
					end
					else
						next_drive = ~tx_sh[14];
				end
				LK_TX_ACK:
				begin
					next_cnt = '0;
					if (rx_sh[0])
					begin
						next_drive = 1'b0;
						next_state = LK_IDLE;
					end
					else
					begin
						next_second = ~second;
						if (second)
							next_tx_sh = {1'b0, snapshot};
						next_drive = ~next_tx_sh[15];
						next_state = LK_TX;
					end
				end
				LK_RX:
				begin
					if (cnt == BIT_LAST)
					begin
						next_cnt = '0;
						next_drive = 1'b1;
						next_state = LK_RX_ACK;
					end
				end
				LK_RX_ACK:
				begin
					next_cnt = '0;
					next_drive = 1'b0;
					next_state = LK_RX;
				end
				LK_IDLE:
				begin
					next_cnt = '0;
					next_drive = 1'b0;
				end
				default:
				begin
					next_cnt = '0;
					next_drive = 1'b0;
					next_state = LK_IDLE;
				end
			endcase
		end
	end

	always_ff @(negedge scl or posedge srst)
	begin
		if (srst)
		begin
			state <= LK_IDLE;
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			seen <= 1'b0;
			drive <= 1'b0;
			cnt <= 4'h0;
			tx_sh <= 16'h0000;
			is_read <= 1'b0;
			second <= 1'b0;
		end
		else
		begin
			state <= next_state;
			tog_s1 <= start_tog;
			tog_s2 <= tog_s1;
			seen <= next_seen;
			drive <= next_drive;
			cnt <= next_cnt;
			tx_sh <= next_tx_sh;
			is_read <= next_is_read;
			second <= next_second;
		end
	end
endmodule

// ### shared/press_pkg.sv
/*
 Constants and types of the pressure readout block: slave address,
 conversion timing, correction figures and the link state encoding.
 Assumes a 200 MHz core clock and a two-wire bus master outside.
*/
// Summary of operation
// - new corrected result roughly every 250 us
// - slave only, never drives clock
// - both lines released while bus idle
// - STOP ends; repeated requests served without STOP
// - data changes only while clock low
// - one clock pulse per data bit
// - 8-bit bytes, most significant bit first
// - receiver pulls data low on ninth pulse
// - master not acknowledging stops slave transmit
// - primary address 1111000 plus direction bit
// - optional secondary address answered as well
// - direction 0 writes, 1 reads
// - read returns two bytes, 15-bit pressure
package press_pkg;
	localparam logic [6:0] PRIMARY_ADDR = 7'h78;
	localparam int MCLK_MHZ = 200;
	localparam int CONV_TIME_NS = 250000;
	localparam int CONV_CYCLES_DEF = CONV_TIME_NS * MCLK_MHZ / 1000;
	localparam int ADC_BITS = 12;
	localparam int PRESS_BITS = 15;
	localparam int PROD_BITS = ADC_BITS + PRESS_BITS;
	localparam logic [14:0] ZERO_OFFSET = 15'h0aab;
	localparam logic [14:0] FULL_SCALE_SPAN = 15'h5555;
	localparam logic [14:0] PRESS_RESET = 15'h0000;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BITS_AT_SYNC = 4'h2;
	typedef enum logic [2:0] {
		LK_IDLE,
		LK_ADDR,
		LK_ADDR_ACK,
		LK_TX,
		LK_TX_ACK,
		LK_RX,
		LK_RX_ACK
	} link_state_t;
endpackage

// ### shared/conv_if.sv
/*
 Carrier between the conversion unit and the readout top.
 Assumes both ends run on the core clock.
*/
`timescale 1ns/1ps
interface conv_if;
	logic tick;
	logic [press_pkg::PRESS_BITS-1:0] result;
	modport unit (output tick, output result);
	modport core (input tick, input result);
endinterface

// ### hw/conv_unit.sv
/*
 Cyclic conversion: corrects the raw converter sample to counts and
 pulses tick once per conversion period.
 Assumes adc_raw comes from logic on mclk.
*/
`timescale 1ns/1ps
module conv_unit
	import press_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DEF
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [ADC_BITS-1:0] adc_raw,
	conv_if.unit cv
);
	localparam int CW = $clog2(CONV_CYCLES);
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic next_tick;
	logic [PRESS_BITS-1:0] next_result;
	logic [PROD_BITS-1:0] prod;

	assign prod = PROD_BITS'(adc_raw) * PROD_BITS'(FULL_SCALE_SPAN);

	always_comb
	begin
		next_cnt = cnt + 1'b1;
		next_tick = 1'b0;
		next_result = cv.result;
		if (cnt == CW'(CONV_CYCLES - 1))
		begin
			next_cnt = '0;
			next_tick = 1'b1;
			next_result = prod[PROD_BITS-1:ADC_BITS] + ZERO_OFFSET;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			cnt <= '0;
			cv.tick <= 1'b0;
			cv.result <= PRESS_RESET;
		end
		else
		begin
			cnt <= next_cnt;
			cv.tick <= next_tick;
			cv.result <= next_result;
		end
	end
endmodule

// ### verification/press_chk.sv
/*
 Checker for press_readout: bus slot timing, release and value pacing.
 Assumes it is bound to press_readout and sees only its ports.
*/
`timescale 1ns/1ps
module press_chk
	import press_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DEF,
	parameter logic SEC_ADDR_EN = 1'b0,
	parameter logic [6:0] SEC_ADDR = 7'h00
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda_i,
	input wire logic [ADC_BITS-1:0] adc_raw,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic [PRESS_BITS-1:0] pressure,
	input wire logic bus_busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	logic [6:0] cnt;
	logic [7:0] sh;
	logic rd;
	logic [31:0] gap;
	logic hit;
	assign hit = sh[7:1] == PRIMARY_ADDR || (SEC_ADDR_EN && sh[7:1] == SEC_ADDR);
	// clock rises since the last start, shifted bits, read flag
	always_ff @(posedge mclk)
	begin
		if (srst || (scl && $fell(sda_i)))
			cnt <= 7'h00;
		else if ($rose(scl))
		begin
			cnt <= cnt + 7'h01;
			sh <= {sh[6:0], sda_i};
			if (cnt == 7'h08)
				rd <= hit && sh[0];
		end
		gap <= srst ? 32'h0fffffff : ($changed(pressure) ? 32'h0 : gap + 32'h1);
	end
	a_open_drain: assert property (sda_o == 1'b0)
		else $error("sda_o not low");
	a_idle_free: assert property (!bus_busy |-> !sda_oe)
		else $error("sda pulled while idle");
	a_low_change: assert property ($changed(sda_oe) |-> !scl)
		else $error("sda_oe moved with scl high");
	a_addr_ack: assert property ($rose(scl) && cnt == 7'h08 |-> sda_oe == hit)
		else $error("address ack wrong");
	a_read_msb: assert property ($rose(scl) && cnt == 7'h09 && rd |-> sda_oe)
		else $error("top read bit not zero");
	a_nack_quit: assert property ($rose(scl) && rd && cnt > 7'h10 && cnt % 9 == 8
		&& sda_i |=> (!sda_oe) [*8])
		else $error("still driving after nack");
	a_busy_start: assert property (scl && $fell(sda_i) |-> ##[1:8] bus_busy)
		else $error("start not seen");
	a_busy_stop: assert property (scl && $rose(sda_i) |-> ##[1:8] !bus_busy)
		else $error("stop not seen");
	a_press_gap: assert property ($changed(pressure) |-> gap >= 32'(CONV_CYCLES - 1))
		else $error("pressure updated too soon");
	c_read: cover property ($rose(scl) && cnt == 7'h09 && rd);
	c_stop: cover property (scl && $rose(sda_i));
	c_tick: cover property ($changed(pressure));
endmodule
bind press_readout press_chk #(.CONV_CYCLES(CONV_CYCLES), .SEC_ADDR_EN(SEC_ADDR_EN),
	.SEC_ADDR(SEC_ADDR)) u_chk (.mclk, .srst, .scl, .sda_i, .adc_raw, .sda_o, .sda_oe,
	.pressure, .bus_busy);

// ### verification/bus_master.sv
/*
 Two-wire bus master model: start, stop and nine-bit slots.
 Assumes the bench resolves sda with a pull-up from both pull-downs.
*/
`timescale 1ns/1ps
module bus_master
(
	output logic scl,
	output logic sda_low,
	input wire logic sda,
	output logic [8:0] seen,
	output logic seen_stb
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
		seen = 9'h000;
		seen_stb = 1'b0;
	end
	task automatic start();
	begin
		#1.3 sda_low = 1'b0;
		#30 scl = 1'b1;
		#40 sda_low = 1'b1;
		#40 scl = 1'b0;
	end
	endtask
	task automatic stop();
	begin
		#10 sda_low = 1'b1;
		#14 scl = 1'b1;
		#40 sda_low = 1'b0;
		#60;
	end
	endtask
	task automatic xfer(input logic [8:0] d);
		logic [8:0] r;
	begin
		// bit slot shortened to 30 ns
		// msb first, data moves while clock low
		for (int i = 8; i >= 0; i--)
		begin
			#10 sda_low = ~d[i];
			#14 scl = 1'b1;
			r[i] = sda;
			#6 scl = 1'b0;
		end
		seen = r;
		seen_stb = 1'b1;
		#1 seen_stb = 1'b0;
	end
	endtask
endmodule

// ### verification/tb.sv
/*
 Bench for press_readout: conversion, reads, repeats, refusals, writes.
 Assumes bus_master as the far side and a pull-up on the data line.
*/
`timescale 1ns/1ps
module tb;
	import press_pkg::*;
	localparam int CONV = 40;
	logic mclk = 1'b0;
	logic srst = 1'b0;
	logic [ADC_BITS-1:0] adc_raw = 12'h000;
	logic scl, sda_low, sda_o, sda_oe, bus_busy, seen_stb;
	logic [PRESS_BITS-1:0] pressure;
	logic [8:0] seen;
	logic [31:0] lfsr = 32'h9618aee3;
	logic [8:0] notes[$];
	int mismatches = 0;
	int cmp_count = 0;
	wire sda = ~(sda_low | (sda_oe & ~sda_o));
	always #2.5 mclk = ~mclk;
	press_readout #(.CONV_CYCLES(CONV), .SEC_ADDR_EN(1'b1), .SEC_ADDR(7'h2a)) DUT (.mclk,
		.srst, .scl, .sda_i(sda), .adc_raw, .sda_o, .sda_oe, .pressure, .bus_busy);
	bus_master m (.scl, .sda_low, .sda, .seen, .seen_stb);
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	end
	endtask
	task automatic wrap_up();
	begin
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [14:0] exp_p(input logic [11:0] r);
		return 15'(ZERO_OFFSET + ((32'(r) * 32'(FULL_SCALE_SPAN)) >> 12));
	endfunction
	task automatic new_raw(output logic [14:0] p);
	begin
		@(negedge mclk);
		lfsr = lfsr_next(lfsr);
		adc_raw = lfsr[11:0];
		p = exp_p(lfsr[11:0]);
	end
	endtask
	task automatic bus(input logic [8:0] d, input logic [8:0] e);
	begin
		notes.push_back(e);
		m.xfer(d);
	end
	endtask
	always @(posedge seen_stb)
	begin
		logic [15:0] exp_byte;
		exp_byte = notes.size() ? {7'h00, notes.pop_front()} : 16'hffff;
		check("bus byte", exp_byte, {7'h00, seen});
	end
	initial
	begin
		logic [14:0] p1;
		logic [14:0] p2;
		// raised after time zero so the link-side flops see an edge
		#1 srst = 1'b1;
		repeat (10) @(posedge mclk);
		@(negedge mclk) srst = 1'b0;
		check("idle", 16'h0000, {sda_oe, pressure});
		new_raw(p1);
		repeat (2 * CONV + 10) @(negedge mclk);
		check("pressure", {1'b0, p1}, {1'b0, pressure});
		new_raw(p2);
		m.start();
		// word held from start, repeats on ack
		bus({PRIMARY_ADDR, 2'b11}, {PRIMARY_ADDR, 2'b10});
		bus(9'h1fe, {1'b0, p1[14:8], 1'b0});
		bus(9'h1fe, {p1[7:0], 1'b0});
		bus(9'h1fe, {1'b0, p1[14:8], 1'b0});
		bus(9'h1ff, {p1[7:0], 1'b1});
		// repeated start on the second address
		m.start();
		bus({7'h2a, 2'b11}, {7'h2a, 2'b10});
		bus(9'h1fe, {1'b0, p2[14:8], 1'b0});
		bus(9'h1ff, {p2[7:0], 1'b1});
		m.stop();
		check("busy", 16'h0000, {15'h0000, bus_busy});
		m.start();
		bus({7'h79, 2'b11}, {7'h79, 2'b11});
		m.stop();
		m.start();
		bus({PRIMARY_ADDR, 2'b01}, {PRIMARY_ADDR, 2'b00});
		bus({lfsr[19:12], 1'b1}, {lfsr[19:12], 1'b0});
		m.stop();
		for (int i = 0; i < 100 && notes.size() > 0; i++)
			@(negedge mclk);
		if (notes.size() > 0)
			mismatches++;
		wrap_up();
	end
endmodule
